// ==== core/nvs_pkg.sv ====
// nvs_pkg: shared constants and carrier types of the serial nonvolatile memory slave
package nvs_pkg;

    // ****************************************************************
    // widths and sizes
    // ****************************************************************
    localparam int          BYTE_W     = 8;
    localparam int          MEM_AW     = 14;
    localparam int          MEM_DEPTH  = 16384;
    localparam int          SYNC_W     = 6;

    // ****************************************************************
    // address word fields
    // ****************************************************************
    // device type code: value is arbitrary, strap it to the system's choice
    localparam logic [3:0]  DEV_TYPE_CODE = 4'h5;
    localparam int          TYPE_MSB      = 7;
    localparam int          TYPE_LSB      = 4;
    localparam int          SEL_MSB       = 3;
    localparam int          SEL_LSB       = 1;
    localparam int          RW_POS        = 0;
    localparam int          HI_ADDR_W     = 6;

    // ****************************************************************
    // counts and reset values
    // ****************************************************************
    localparam logic [3:0]        BIT_CNT_FULL = 4'h8;
    localparam logic [3:0]        BIT_CNT_RST  = 4'h0;
    localparam logic [MEM_AW-1:0] ADDR_RST     = 14'h0000;
    localparam logic [MEM_AW-1:0] ADDR_ONE     = 14'h0001;
    localparam logic [7:0]        BYTE_RST     = 8'h00;
    localparam logic [5:0]        HI_RST       = 6'h00;
    localparam logic [SYNC_W-1:0] PINS_RST     = 6'h30;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_DEVW   = 4'h1,
        ST_AHI    = 4'h2,
        ST_ALO    = 4'h3,
        ST_WDAT   = 4'h4,
        ST_RDAT   = 4'h5,
        ST_MACK   = 4'h6,
        ST_IGNORE = 4'h7
    } nvs_state_t;

    // pins as seen by the sampling clock
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [2:0] sel;
    } nvs_pins_t;

    // one byte committed to the array
    typedef struct packed {
        logic              en;
        logic [MEM_AW-1:0] addr;
        logic [7:0]        data;
    } nvs_wr_t;

endpackage

// ==== core/nvs_sync.sv ====
// nvs_sync: two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module nvs_sync (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // asynchronous pins in, synchronised pins out
    input  wire logic [nvs_pkg::SYNC_W-1:0] din,
    output logic      [nvs_pkg::SYNC_W-1:0] dout
);
    import nvs_pkg::*;

    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;

    // idle bus levels at reset keep a false start from showing up
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    meta_ff[i] <= PINS_RST[i];
                    sync_ff[i] <= PINS_RST[i];
                end else begin
                    meta_ff[i] <= din[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign dout = sync_ff;

endmodule
`default_nettype wire

// ==== core/nvs_mem.sv ====
// nvs_mem: byte storage array with one write and one registered read port
`timescale 1ns/1ps
`default_nettype none
module nvs_mem (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // write port
    input  wire nvs_pkg::nvs_wr_t          wr,
    // read port, one cycle latency
    input  wire logic [nvs_pkg::MEM_AW-1:0] rd_addr,
    output logic      [7:0]                rd_data
);
    import nvs_pkg::*;

    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] rd_data_ff;

    // array has no reset: contents survive, as nonvolatile storage should
    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data_ff <= BYTE_RST;
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_ff;

endmodule
`default_nettype wire

// ==== core/nvs_slave.sv ====
// nvs_slave: two-wire serial slave front end of a 16K x 8 nonvolatile memory
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - first byte after start: 4-bit type, 3-bit select, 1-bit direction
// - respond only when the received type equals the fixed type code
// - respond only when select bits equal the strapped select pins
// - direction bit low means write, high means read
// - matching address word is acknowledged by pulling data low on clock nine
// - write: two address bytes, high first, each acknowledged
// - after address phase, bytes of eight bits each with ninth-clock acknowledge
// - device acknowledges every write byte; master waits for it
// - read: device drives eight bits, releases, samples master acknowledge
// - write-protect high blocks all writes; low allows all writes
// - write-protect has pull-down; floating reads low, writes allowed
// - byte committed as its acknowledge begins, on the eighth clock fall; never busy
// - byte write: address word, two address bytes, one data byte, stop
// - further write bytes go to successive addresses, wrapping to zero
// - read without address phase returns last accessed address plus one
// - address counter wraps to zero past the last location
// - address counter undefined until a transaction loads it; here reset loads zero
// - random read: write address phase, repeated start, read address word
// - acknowledged reads continue at incrementing, wrapping addresses
// - start and stop are data edges while clock high
// - sample data on clock rise, change output after clock fall
// - reads always allowed whatever the write-protect level
module nvs_slave (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // serial bus, data is open drain
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // static straps
    input  wire logic wp,
    input  wire logic addr_select_pin_bit0,
    input  wire logic addr_select_pin_bit1,
    input  wire logic addr_select_pin_bit2
);
    import nvs_pkg::*;

    // ****************************************************************
    // pin sampling
    // ****************************************************************
    nvs_pins_t pins_raw;
    nvs_pins_t pins_s;

    // select order: pin 2 is the msb of the select field
    assign pins_raw.scl = scl;
    assign pins_raw.sda = sda_in;
    assign pins_raw.wp  = wp;
    assign pins_raw.sel = {addr_select_pin_bit2, addr_select_pin_bit1, addr_select_pin_bit0};

    nvs_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (pins_raw),
        .dout (pins_s)
    );

    // ****************************************************************
    // bus condition detection
    // ****************************************************************
    logic scl_q_ff;
    logic sda_q_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= pins_s.scl;
            sda_q_ff <= pins_s.sda;
        end
    end

    wire scl_rise   = pins_s.scl & ~scl_q_ff;
    wire scl_fall   = ~pins_s.scl & scl_q_ff;
    wire scl_high   = pins_s.scl & scl_q_ff;
    wire start_cond = scl_high & sda_q_ff & ~pins_s.sda;
    wire stop_cond  = scl_high & ~sda_q_ff & pins_s.sda;

    // ****************************************************************
    // state and datapath registers
    // ****************************************************************
    nvs_state_t        state_ff;
    nvs_state_t        nxt_state;
    logic [3:0]        cnt_ff;
    logic [3:0]        nxt_cnt;
    logic              ack_ff;
    logic              nxt_ack;
    logic              oe_ff;
    logic              nxt_oe;
    logic [7:0]        sh_ff;
    logic [7:0]        nxt_sh;
    logic [5:0]        hi_ff;
    logic [5:0]        nxt_hi;
    logic [MEM_AW-1:0] addr_ff;
    logic [MEM_AW-1:0] nxt_addr;
    logic              macked_ff;
    logic              nxt_macked;
    nvs_wr_t           wr_ff;
    nvs_wr_t           nxt_wr;
    logic [7:0]        rd_data;

    // ****************************************************************
    // byte decode
    // ****************************************************************
    wire       type_ok  = sh_ff[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE;
    wire       sel_ok   = sh_ff[SEL_MSB:SEL_LSB] == pins_s.sel;
    wire       dev_hit  = type_ok & sel_ok;
    wire       dir_read = sh_ff[RW_POS];
    // the pad pull-down makes an open pin arrive here as a low level
    wire       wr_block = pins_s.wp;
    wire       byte_in  = cnt_ff == BIT_CNT_FULL;
    wire [MEM_AW-1:0] addr_inc = addr_ff + ADDR_ONE;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_ack    = ack_ff;
        nxt_oe     = oe_ff;
        nxt_sh     = sh_ff;
        nxt_hi     = hi_ff;
        nxt_addr   = addr_ff;
        nxt_macked = macked_ff;
        nxt_wr     = '{en: 1'b0, addr: addr_ff, data: sh_ff};
        if (stop_cond) begin
            // ends any transfer; the counter keeps the last address plus one
            nxt_state = ST_IDLE;
            nxt_cnt   = BIT_CNT_RST;
            nxt_ack   = 1'b0;
            nxt_oe    = 1'b0;
        end else if (start_cond) begin
            nxt_state = ST_DEVW;
            nxt_cnt   = BIT_CNT_RST;
            nxt_ack   = 1'b0;
            nxt_oe    = 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE, ST_IGNORE: begin
                    // line stays released until the next start
                    nxt_oe = 1'b0;
                end
                ST_DEVW, ST_AHI, ST_ALO, ST_WDAT: begin
                    if (scl_rise && !ack_ff && !byte_in) begin
                        nxt_sh  = {sh_ff[6:0], pins_s.sda};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && !ack_ff && byte_in) begin
                        // eighth bit taken: decide on the ninth-clock answer
                        nxt_ack = 1'b1;
                        nxt_oe  = 1'b1;
                        unique case (state_ff)
                            ST_DEVW: begin
                                if (!dev_hit) begin
                                    nxt_ack   = 1'b0;
                                    nxt_oe    = 1'b0;
                                    nxt_state = ST_IGNORE;
                                end
                            end
                            ST_AHI: begin
                                // top two bits are expected zero and dropped
                                nxt_hi = sh_ff[HI_ADDR_W-1:0];
                            end
                            ST_ALO: begin
                                nxt_addr = {hi_ff, sh_ff};
                            end
                            default: begin
                                // commit at once; a protected byte is acked and dropped
                                nxt_wr.en = ~wr_block;
                                nxt_addr  = addr_inc;
                            end
                        endcase
                    end else if (scl_fall && ack_ff) begin
                        // ninth clock over: release and move on
                        nxt_ack = 1'b0;
                        nxt_oe  = 1'b0;
                        nxt_cnt = BIT_CNT_RST;
                        unique case (state_ff)
                            ST_DEVW: begin
                                if (dir_read) begin
                                    // current address read, or second half of a random read
                                    nxt_state = ST_RDAT;
                                    nxt_sh    = rd_data;
                                    nxt_oe    = ~rd_data[7];
                                end else begin
                                    nxt_state = ST_AHI;
                                end
                            end
                            ST_AHI:  nxt_state = ST_ALO;
                            default: nxt_state = ST_WDAT;
                        endcase
                    end
                end
                ST_RDAT: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == BIT_CNT_FULL) begin
                            // eight bits out: let go for the master's answer
                            nxt_oe     = 1'b0;
                            nxt_addr   = addr_inc;
                            nxt_macked = 1'b0;
                            nxt_state  = ST_MACK;
                        end else begin
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_oe = ~sh_ff[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        nxt_macked = ~pins_s.sda;
                    end else if (scl_fall) begin
                        nxt_cnt = BIT_CNT_RST;
                        if (macked_ff) begin
                            // read data was refetched from the bumped counter
                            nxt_state = ST_RDAT;
                            nxt_sh    = rd_data;
                            nxt_oe    = ~rd_data[7];
                        end else begin
                            // no acknowledge: wait for the stop
                            nxt_state = ST_IGNORE;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_oe    = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // one register per block keeps each reset value beside its next value
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_ff <= BIT_CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    // pin drive comes straight from a flop, so no decode glitch reaches the wire
    always_ff @(posedge clk) begin
        if (!rstn) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= nxt_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            macked_ff <= 1'b0;
        end else begin
            macked_ff <= nxt_macked;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sh_ff <= BYTE_RST;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hi_ff <= HI_RST;
        end else begin
            hi_ff <= nxt_hi;
        end
    end

    // counter resets to zero only to give it a defined value in simulation
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_ff <= ADDR_RST;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
        end
    end

    // ****************************************************************
    // storage
    // ****************************************************************
    // read port follows the counter every cycle, long before the next clock fall
    nvs_mem u_mem (
        .clk     (clk),
        .rstn    (rstn),
        .wr      (wr_ff),
        .rd_addr (addr_ff),
        .rd_data (rd_data)
    );

    // ****************************************************************
    // pin drive
    // ****************************************************************
    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_ff;

endmodule
`default_nettype wire

// ==== bench/nvs_slave_props.sv ====
// nvs_slave_props: protocol checker bound to the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_props
    import nvs_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // serial bus
    input  wire logic scl,
    input  wire logic sda_in,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    // straps
    input  wire logic wp,
    input  wire logic addr_select_pin_bit0,
    input  wire logic addr_select_pin_bit1,
    input  wire logic addr_select_pin_bit2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ****************************
    // pin-level frame tracker
    // ****************************
    logic       scl_ff, sda_ff, first_ff, act_ff, rd_ff, ign_ff;
    logic [3:0] bcnt_ff;
    logic [7:0] sh_ff;
    wire        start_w = scl && scl_ff && sda_ff && !sda_in;
    wire        stop_w  = scl && scl_ff && !sda_ff && sda_in;
    wire        rise_w  = scl && !scl_ff;
    wire        fall_w  = !scl && scl_ff;
    wire [2:0]  pins_w  = {addr_select_pin_bit2, addr_select_pin_bit1, addr_select_pin_bit0};
    wire        am_w    = first_ff && sh_ff[7:4] == DEV_TYPE_CODE && sh_ff[3:1] == pins_w;
    wire        wrel_w  = first_ff ? (am_w && !sh_ff[0]) : (act_ff && !rd_ff);

    // tracker samples the raw pins, so it leads the design by the synchroniser depth
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {scl_ff, sda_ff} <= 2'h3;
            bcnt_ff          <= 4'h0;
            sh_ff            <= 8'h00;
            {first_ff, act_ff, rd_ff, ign_ff} <= 4'h0;
        end else begin
            scl_ff <= scl;
            sda_ff <= sda_in;
            if (start_w || stop_w) begin
                bcnt_ff                   <= 4'h0;
                first_ff                  <= start_w;
                {act_ff, ign_ff}          <= 2'h0;
            end else if (rise_w && bcnt_ff != 4'h9) begin
                bcnt_ff <= bcnt_ff + 4'h1;
                if (bcnt_ff < 4'h8) sh_ff <= {sh_ff[6:0], sda_in};
                if (bcnt_ff == 4'h8 && act_ff && rd_ff && sda_in) ign_ff <= 1'b1;
            end else if (fall_w && bcnt_ff == 4'h9) begin
                bcnt_ff  <= 4'h0;
                first_ff <= 1'b0;
                if (first_ff) begin
                    act_ff <= am_w;
                    rd_ff  <= sh_ff[0];
                    ign_ff <= !am_w;
                end
            end
        end
    end

    // ****************************
    // properties
    // ****************************
    sequence s_ack_slot; fall_w && bcnt_ff == 4'h8; endsequence
    sequence s_stop; stop_w; endsequence

    property p_addr_ack; s_ack_slot ##0 am_w |-> ##[1:5] sda_oe; endproperty
    property p_data_ack;
        s_ack_slot ##0 (act_ff && !rd_ff && !first_ff) |-> ##[1:5] sda_oe;
    endproperty
    property p_ack_release; fall_w && bcnt_ff == 4'h9 && wrel_w |-> ##[1:5] !sda_oe; endproperty
    property p_rd_release;
        s_ack_slot ##0 (act_ff && rd_ff && !first_ff) |-> ##[1:5] !sda_oe;
    endproperty
    property p_oe_edge; $changed(sda_oe) |-> !$past(scl, 2); endproperty
    property p_od_low; sda_oe |-> sda_out == 1'b0; endproperty
    property p_stop_quiet; s_stop |-> !sda_oe [*8]; endproperty
    property p_ignore; ign_ff |-> !sda_oe; endproperty

    a_addr_ack: assert property (p_addr_ack) else $error("address word not acknowledged");
    a_data_ack: assert property (p_data_ack) else $error("write byte not acknowledged");
    a_ack_release: assert property (p_ack_release) else $error("ack not released");
    a_rd_release: assert property (p_rd_release) else $error("read ack slot driven");
    a_oe_edge: assert property (p_oe_edge) else $error("data changed off clock low");
    a_od_low: assert property (p_od_low) else $error("data pin driven high");
    a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
    a_ignore: assert property (p_ignore) else $error("drive while ignoring bus");
endmodule

bind nvs_slave nvs_slave_props props_u (.clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .addr_select_pin_bit0(addr_select_pin_bit0),
    .addr_select_pin_bit1(addr_select_pin_bit1), .addr_select_pin_bit2(addr_select_pin_bit2));
`default_nettype wire

// ==== bench/nvs_bus_master.sv ====
// nvs_bus_master: behavioural two-wire bus master facing the slave
`timescale 1ns/1ps
`default_nettype none
module nvs_bus_master (
    // clock
    input  wire logic clk,
    // bus: clock out, data pulled low while pull_low is high
    output var logic  scl,
    output var logic  pull_low,
    input  wire logic sda
);
    // clock stands high between frames
    initial begin
        scl      = 1'b1;
        pull_low = 1'b0;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // also serves as repeated start, entered with clock low
    task automatic start_cond;
        pull_low = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(4);
        pull_low = 1'b1;
        tk(4);
        scl = 1'b0;
    endtask

    task automatic stop_cond;
        pull_low = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(4);
        pull_low = 1'b0;
        tk(4);
    endtask

    // data set while clock low, sampled at the end of clock high
    task automatic put_bit(input logic b, output logic s);
        pull_low = !b;
        tk(4);
        scl = 1'b1;
        tk(4);
        s   = sda;
        scl = 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic recv_byte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
        put_bit(!mack, s);
    endtask
endmodule
`default_nettype wire

// ==== bench/test_nvs_slave.sv ====
// test_nvs_slave: self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module test_nvs_slave;
    import nvs_pkg::*;

    logic       clk, rstn, wp, m_scl, m_low, dut_oe, dut_out;
    logic [2:0] sel;
    wire        sda_wire;
    int         errors, cmp_count, cycles;

    // open drain data wire with pull-up
    assign sda_wire = (dut_oe ? dut_out : 1'b1) & !m_low;

    nvs_slave dut_u (.clk(clk), .rstn(rstn), .scl(m_scl), .sda_in(sda_wire), .sda_out(dut_out),
        .sda_oe(dut_oe), .wp(wp), .addr_select_pin_bit0(sel[0]), .addr_select_pin_bit1(sel[1]),
        .addr_select_pin_bit2(sel[2]));
    nvs_bus_master mst_u (.clk(clk), .scl(m_scl), .pull_low(m_low), .sda(sda_wire));

    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    // ****************************
    // timeout and report
    // ****************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH at %0t: timeout", $time);
            stop_test();
        end
    end

    task automatic stop_test;
        $display("counts: %0d mismatches in %0d comparisons", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ****************************
    // transfers
    // ****************************
    task automatic set_addr(input logic [13:0] a);
        logic ack;
        mst_u.start_cond();
        mst_u.send_byte({DEV_TYPE_CODE, sel, 1'b0}, ack);
        check({7'h0, ack}, 8'h01, "address word ack");
        mst_u.send_byte({2'b00, a[13:8]}, ack);
        check({7'h0, ack}, 8'h01, "high address ack");
        mst_u.send_byte(a[7:0], ack);
        check({7'h0, ack}, 8'h01, "low address ack");
    endtask

    task automatic wr_mem(input logic [13:0] a, input logic [7:0] d[$]);
        logic ack;
        set_addr(a);
        foreach (d[i]) begin
            mst_u.send_byte(d[i], ack);
            check({7'h0, ack}, 8'h01, "data ack");
        end
        mst_u.stop_cond();
    endtask

    // rnd low gives a current address read
    task automatic rd_mem(input logic rnd, input logic [13:0] a, input logic [7:0] exp[$]);
        logic       ack;
        logic [7:0] b;
        if (rnd) set_addr(a);
        mst_u.start_cond();
        mst_u.send_byte({DEV_TYPE_CODE, sel, 1'b1}, ack);
        check({7'h0, ack}, 8'h01, "read address ack");
        foreach (exp[i]) begin
            mst_u.recv_byte(i != exp.size() - 1, b);
            check(b, exp[i], "read data");
        end
        mst_u.stop_cond();
    endtask

    // ****************************
    // scenarios
    // ****************************
    task automatic t_write_read;
        wr_mem(14'h0123, '{8'ha5});
        rd_mem(1'b1, 14'h0123, '{8'ha5});
        $display("test write_read done");
    endtask

    task automatic t_page_wrap;
        wr_mem(14'h3ffe, '{8'h11, 8'h22, 8'h33, 8'h44});
        rd_mem(1'b1, 14'h3ffe, '{8'h11, 8'h22, 8'h33});
        rd_mem(1'b0, 14'h0000, '{8'h44});
        $display("test page_wrap done");
    endtask

    // protected bytes are acked and advance the counter, so 3ffe+2 lands on 0000
    task automatic t_protect;
        wp = 1'b1;
        wr_mem(14'h3ffe, '{8'h77, 8'h88});
        rd_mem(1'b0, 14'h0000, '{8'h33});
        rd_mem(1'b1, 14'h3ffe, '{8'h11, 8'h22});
        wp = 1'b0;
        $display("test protect done");
    endtask

    task automatic t_select;
        logic ack;
        for (int s = 0; s < 8; s++) begin
            sel = 3'(s);
            mst_u.tk(4);
            mst_u.start_cond();
            mst_u.send_byte({DEV_TYPE_CODE, sel, 1'b0}, ack);
            check({7'h0, ack}, 8'h01, "matching select ack");
            mst_u.start_cond();
            mst_u.send_byte({DEV_TYPE_CODE, sel ^ 3'h4, 1'b1}, ack);
            check({7'h0, ack}, 8'h00, "wrong select ack");
            mst_u.send_byte(8'h00, ack);
            check({7'h0, ack}, 8'h00, "ignored byte ack");
            mst_u.start_cond();
            mst_u.send_byte({4'h6, sel, 1'b0}, ack);
            check({7'h0, ack}, 8'h00, "wrong type ack");
            mst_u.stop_cond();
        end
        sel = 3'h5;
        $display("test select done");
    endtask

    task automatic t_abort;
        logic ack;
        logic s;
        set_addr(14'h0200);
        mst_u.send_byte(8'h99, ack);
        mst_u.put_bit(1'b0, s);
        mst_u.put_bit(1'b1, s);
        wr_mem(14'h0201, '{8'h3c});
        rd_mem(1'b1, 14'h0200, '{8'h99, 8'h3c});
        $display("test abort done");
    endtask

    initial begin
        wp   = 1'b0;
        sel  = 3'h5;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        mst_u.tk(4);
        t_write_read();
        t_page_wrap();
        t_protect();
        t_select();
        t_abort();
        stop_test();
    end
endmodule
`default_nettype wire
